// >>> core/uabd_regs.svh
// Constants for the auto-baud detect block
`ifndef UABD_REGS_SVH
`define UABD_REGS_SVH
// Sync character expected from the remote transmitter
`define UABD_SYNC_CHAR 8'h55
// Rising edges in the sync character, stop-bit edge included
`define UABD_SYNC_EDGES 3'h5
// Counter start value during calibration
`define UABD_CNT_START 16'h0001
// Base clock prescale, log2: 64, 16, 4
`define UABD_BASE_LOG2_SLOW 4'h6
`define UABD_BASE_LOG2_MID 4'h4
`define UABD_BASE_LOG2_FAST 4'h2
// Calibration clock is base divided by 8, log2
`define UABD_ABD_EXTRA_LOG2 4'h3
// Prescaler width: enough for Fosc/512
`define UABD_PRE_W 9
`endif

// >>> core/uabd_pkg.sv
// Types for the auto-baud detect block
`default_nettype none
package uabd_pkg;
  typedef enum logic [1:0] {
    UABD_IDLE = 2'b00,
    UABD_WAKE = 2'b01,
    UABD_WAIT_START = 2'b11,
    UABD_MEASURE = 2'b10
  } uabd_state_t;
endpackage : uabd_pkg
`default_nettype wire

// >>> core/uabd_core.sv
// Auto-baud detect with baud generator and wake-on-break
// Operation
// RULE1: Receive line times divisor counter during detection
// RULE2: Remote sends sync character 55h, five rises
// RULE3: Enable starts calibration; receiver held idle
// RULE4: Counting starts on first rise after start
// RULE5: Fifth rise stores count, clears enable, flags
// RULE6: Holding register read clears receive flag
// RULE7: Software checks high byte 00h for overflow
// RULE8: Both divisor bytes form one 16-bit counter
// RULE9: Calibration counter runs at base clock/8
// RULE10: Prescale from width and speed selections
// RULE11: With wake enabled, measure character after break
// RULE12: Counter starts at one
// RULE13: Software subtracts one after calibration
// RULE14: Software ensures baud rate is measurable
// RULE15: Break end rise clears wake enable
// RULE16: Tick every divisor-plus-one base periods
`include "uabd_regs.svh"
`default_nettype none
module uabd_core
  import uabd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic rx_i,
  input wire logic wide_divisor_select_i,
  input wire logic high_speed_select_i,
  input wire logic auto_baud_set_i,
  input wire logic wake_set_i,
  input wire logic divisor_wr_i,
  input wire logic [15:0] divisor_wdata_i,
  input wire logic holding_rd_i,
  output logic auto_baud_enable_o,
  output logic wake_on_break_enable_o,
  output logic receive_interrupt_flag_o,
  output logic [7:0] divisor_high_byte_o,
  output logic [7:0] divisor_low_byte_o,
  output logic rx_hold_idle_o,
  output logic baud_tick_o
);
  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  logic rx_m_q, rx_m_d, rx_s_q, rx_s_d, rx_p_q, rx_p_d;
  always_comb begin
    rx_m_d = rx_i;
    rx_s_d = rx_m_q;
    rx_p_d = rx_s_q;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
    end else if (clk_en_i) begin
      rx_m_q <= rx_m_d;
      rx_s_q <= rx_s_d;
      rx_p_q <= rx_p_d;
    end
  end
  logic rx_rise, rx_fall;
  assign rx_rise = rx_s_q & ~rx_p_q;
  assign rx_fall = ~rx_s_q & rx_p_q;

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [`UABD_PRE_W-1:0] pre_q, pre_d;
  logic [3:0] base_log2;
  logic [3:0] abd_log2;
  logic base_stb, abd_stb;
  logic measuring;
  always_comb begin
    unique case ({wide_divisor_select_i, high_speed_select_i}) // RULE10
      2'b00: base_log2 = `UABD_BASE_LOG2_SLOW;
      2'b11: base_log2 = `UABD_BASE_LOG2_FAST;
      default: base_log2 = `UABD_BASE_LOG2_MID;
    endcase
    abd_log2 = base_log2 + `UABD_ABD_EXTRA_LOG2; // RULE9
  end
  // Free-running counter; the strobe fires while the low bits are all ones, the cycle before they wrap
  logic [`UABD_PRE_W-1:0] base_mask, abd_mask;
  assign base_mask = `UABD_PRE_W'((10'h001 << base_log2) - 10'h001);
  assign abd_mask = `UABD_PRE_W'((10'h001 << abd_log2) - 10'h001);
  assign base_stb = (pre_q & base_mask) == base_mask;
  assign abd_stb = (pre_q & abd_mask) == abd_mask;
  always_comb begin
    pre_d = pre_q + `UABD_PRE_W'(1);
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pre_q <= '0;
    end else if (clk_en_i) begin
      pre_q <= pre_d;
    end
  end

  // ****************************************************************
  // Detect control and divisor
  // ****************************************************************
  uabd_state_t st_q, st_d;
  logic auto_baud_enable_q, auto_baud_enable_d, wue_q, wue_d, flag_q, flag_d;
  logic [15:0] div_q, div_d;
  logic [2:0] edges_q, edges_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic tick_q, tick_d, hold_q, hold_d;
  logic [15:0] div_eff;
  assign measuring = (st_q == UABD_MEASURE);
  always_comb begin
    st_d = st_q;
    auto_baud_enable_d = auto_baud_enable_q | auto_baud_set_i;
    wue_d = wue_q | wake_set_i;
    flag_d = flag_q;
    div_d = div_q;
    edges_d = edges_q;
    if (divisor_wr_i) begin
      div_d = divisor_wdata_i;
    end
    if (holding_rd_i) begin
      flag_d = 1'b0; // RULE6
    end
    unique case (st_q)
      UABD_IDLE: begin
        if (wue_q) begin
          st_d = UABD_WAKE; // RULE11
        end else if (auto_baud_enable_q) begin
          st_d = UABD_WAIT_START;
        end
      end
      UABD_WAKE: begin
        // Falling edge is the wake event; the next rise ends the break
        if (rx_fall) begin
          flag_d = 1'b1;
        end
        if (rx_rise) begin
          wue_d = 1'b0; // RULE15
          st_d = UABD_IDLE;
        end
      end
      UABD_WAIT_START: begin
        if (!auto_baud_enable_q) begin
          st_d = UABD_IDLE;
        end else if (rx_rise) begin
          div_d = `UABD_CNT_START; // RULE4 RULE12
          edges_d = 3'h1;
          st_d = UABD_MEASURE;
        end
      end
      UABD_MEASURE: begin
        if (abd_stb) begin
          div_d = div_q + 16'h0001; // RULE1 RULE8
        end
        if (rx_rise) begin
          edges_d = edges_q + 3'h1;
          if (edges_q == `UABD_SYNC_EDGES - 3'h1) begin
            auto_baud_enable_d = 1'b0; // RULE5
            flag_d = 1'b1;
            div_d = div_q;
            st_d = UABD_IDLE;
          end
        end
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q <= UABD_IDLE;
      auto_baud_enable_q <= 1'b0;
      wue_q <= 1'b0;
      flag_q <= 1'b0;
      div_q <= 16'h0000;
      edges_q <= 3'h0;
    end else if (clk_en_i) begin
      st_q <= st_d;
      auto_baud_enable_q <= auto_baud_enable_d;
      wue_q <= wue_d;
      flag_q <= flag_d;
      div_q <= div_d;
      edges_q <= edges_d;
    end
  end

  // ****************************************************************
  // Baud tick generator
  // ****************************************************************
  assign div_eff = wide_divisor_select_i ? div_q : {8'h00, div_q[7:0]};
  always_comb begin
    tcnt_d = tcnt_q;
    tick_d = 1'b0;
    // Receiver held idle through wake and calibration
    hold_d = (st_d != UABD_IDLE) | auto_baud_enable_d | wue_d; // RULE3
    if (measuring || !base_stb) begin
      tcnt_d = measuring ? 16'h0000 : tcnt_q;
    end else if (tcnt_q >= div_eff) begin
      tcnt_d = 16'h0000; // RULE16
      tick_d = 1'b1;
    end else begin
      tcnt_d = tcnt_q + 16'h0001;
    end
  end
  // Tick and hold state registered apart from the detect state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tcnt_q <= 16'h0000;
      tick_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (clk_en_i) begin
      tcnt_q <= tcnt_d;
      tick_q <= tick_d;
      hold_q <= hold_d;
    end
  end
  assign auto_baud_enable_o = auto_baud_enable_q;
  assign wake_on_break_enable_o = wue_q;
  assign receive_interrupt_flag_o = flag_q;
  assign divisor_high_byte_o = div_q[15:8];
  assign divisor_low_byte_o = div_q[7:0];
  assign rx_hold_idle_o = hold_q;
  assign baud_tick_o = tick_q;
endmodule : uabd_core
`default_nettype wire

// >>> tb/uabd_remote.sv
// Remote transmitter model: optional break, then the sync character
`default_nettype none
module uabd_remote (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic brk_i,
  input wire logic [15:0] bit_cyc_i,
  output logic rx_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rx_o, busy_o} = 2'h2;
  // Sixteen bit times, LSB first; idle is high
  task send(input logic [15:0] f);
    for (int i = 0; i < 16; i++) begin
      rx_o <= f[i];
      repeat (bit_cyc_i) @(posedge mclk_i);
    end
  endtask : send
  always @(posedge mclk_i) begin
    if (go_i) begin
      busy_o <= 1'h1;
      if (brk_i) send(16'hc000);
      send(16'hfeaa);
      busy_o <= 1'h0;
    end
  end
endmodule : uabd_remote
`default_nettype wire

// >>> tb/uabd_core_props.sv
// Port checks for the auto-baud detect block
`default_nettype none
module uabd_core_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic auto_baud_set_i,
  input wire logic divisor_wr_i,
  input wire logic holding_rd_i,
  input wire logic auto_baud_enable_o,
  input wire logic wake_on_break_enable_o,
  input wire logic receive_interrupt_flag_o,
  input wire logic [7:0] divisor_high_byte_o,
  input wire logic [7:0] divisor_low_byte_o,
  input wire logic rx_hold_idle_o,
  input wire logic baud_tick_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_done_flag: assert property ($fell(auto_baud_enable_o) |-> receive_interrupt_flag_o)
    else $error("flag not raised at end of calibration");
  a_done_nonzero: assert property ($fell(auto_baud_enable_o) |->
    {divisor_high_byte_o, divisor_low_byte_o} != 16'h0000)
    else $error("divisor zero after calibration");
  a_div_frozen: assert property (!auto_baud_enable_o && !$past(auto_baud_enable_o) &&
    !divisor_wr_i |=> $stable({divisor_high_byte_o, divisor_low_byte_o}))
    else $error("divisor moved outside calibration");
  a_flag_read: assert property (receive_interrupt_flag_o && holding_rd_i && clk_en_i &&
    !auto_baud_enable_o |=> !receive_interrupt_flag_o)
    else $error("read did not clear flag");
  a_enable_set: assert property (auto_baud_set_i && clk_en_i |=> auto_baud_enable_o)
    else $error("enable not set");
  a_hold_idle: assert property (auto_baud_enable_o && $past(auto_baud_enable_o) |->
    rx_hold_idle_o)
    else $error("receiver not held idle");
  // A frozen clock holds the tick, so only a running one must drop it
  a_tick_pulse: assert property (baud_tick_o && clk_en_i |=> !baud_tick_o)
    else $error("tick longer than one cycle");
  a_wake_flag: assert property ($fell(wake_on_break_enable_o) |-> receive_interrupt_flag_o)
    else $error("break end without flag");
endmodule : uabd_core_props
bind uabd_core uabd_core_props uabd_core_props_inst (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i),
  .auto_baud_set_i(auto_baud_set_i),
  .divisor_wr_i(divisor_wr_i),
  .holding_rd_i(holding_rd_i),
  .auto_baud_enable_o(auto_baud_enable_o),
  .wake_on_break_enable_o(wake_on_break_enable_o),
  .receive_interrupt_flag_o(receive_interrupt_flag_o),
  .divisor_high_byte_o(divisor_high_byte_o),
  .divisor_low_byte_o(divisor_low_byte_o),
  .rx_hold_idle_o(rx_hold_idle_o),
  .baud_tick_o(baud_tick_o)
);
`default_nettype wire

// >>> tb/test_uabd_core.sv
// Self-checking bench for the auto-baud detect block
`default_nettype none
module test_uabd_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_n_i = 0, clk_en_i = 1, rx_i, wide_divisor_select_i = 0;
  logic high_speed_select_i = 0, auto_baud_set_i = 0, wake_set_i = 0, divisor_wr_i = 0;
  logic holding_rd_i = 0, go = 0, brk = 0, busy, auto_baud_enable_o, wake_on_break_enable_o;
  logic receive_interrupt_flag_o, rx_hold_idle_o, baud_tick_o;
  logic [7:0] divisor_high_byte_o, divisor_low_byte_o;
  logic [15:0] divisor_wdata_i = 0, bitc = 0, d;
  int seed = 92, n_mismatch = 0, checks = 0, t;
  uabd_core uabd_core_inst (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .rx_i(rx_i),
    .wide_divisor_select_i(wide_divisor_select_i),
    .high_speed_select_i(high_speed_select_i),
    .auto_baud_set_i(auto_baud_set_i),
    .wake_set_i(wake_set_i),
    .divisor_wr_i(divisor_wr_i),
    .divisor_wdata_i(divisor_wdata_i),
    .holding_rd_i(holding_rd_i),
    .auto_baud_enable_o(auto_baud_enable_o),
    .wake_on_break_enable_o(wake_on_break_enable_o),
    .receive_interrupt_flag_o(receive_interrupt_flag_o),
    .divisor_high_byte_o(divisor_high_byte_o),
    .divisor_low_byte_o(divisor_low_byte_o),
    .rx_hold_idle_o(rx_hold_idle_o),
    .baud_tick_o(baud_tick_o)
  );
  uabd_remote uabd_remote_inst (.mclk_i(mclk_i), .go_i(go), .brk_i(brk), .bit_cyc_i(bitc),
    .rx_o(rx_i), .busy_o(busy));
  initial forever #50 mclk_i = ~mclk_i;
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task cmp(input string what, input logic [15:0] got, exp, tol);
    checks++;
    if ((16'(got - exp + tol) <= 16'(2 * tol)) !== 1'h1) begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp
  task hang(input logic bad);
    if (bad) begin
      n_mismatch++;
      results();
    end
  endtask : hang
  function int base(input logic [1:0] md);
    return md == 0 ? 64 : md == 3 ? 4 : 16;
  endfunction : base
  task calib(input logic [1:0] md, input int mm, input logic wk);
    {wide_divisor_select_i, high_speed_select_i} = md;
    bitc = 16'(base(md) * mm);
    auto_baud_set_i = 1;
    wake_set_i = wk;
    brk = wk;
    go = 1;
    cyc(1);
    {auto_baud_set_i, wake_set_i, go} = 3'h0;
    cmp("hold", rx_hold_idle_o, 1, 0);
    for (t = 0; auto_baud_enable_o !== 1'h0 && t < 40000; t++) cyc(1);
    hang(t == 40000);
    // Start value one plus one count per eight base periods over eight bits; prescaler phase gives +-1
    d = {divisor_high_byte_o, divisor_low_byte_o};
    cmp("divisor", d, 16'(mm + 1), 1);
    cmp("corrected divisor", 16'(d - 16'h0001), 16'(mm), 1);
    if (!md[1]) cmp("high byte", divisor_high_byte_o, 0, 0);
    cmp("flag", receive_interrupt_flag_o, 1, 0);
    // Frozen clock: the read must not land until the enable returns
    clk_en_i = 0;
    holding_rd_i = 1;
    cyc(3);
    cmp("frozen flag", receive_interrupt_flag_o, 1, 0);
    clk_en_i = 1;
    cyc(1);
    holding_rd_i = 0;
    cyc(1);
    cmp("flag", receive_interrupt_flag_o, 0, 0);
    cmp("wake", wake_on_break_enable_o, 0, 0);
    for (t = 0; busy !== 1'h0 && t < 20000; t++) cyc(1);
    hang(t == 20000);
    cmp("hold", rx_hold_idle_o, 0, 0);
  endtask : calib
  task wt();
    t = 0;
    do begin
      cyc(1);
      t++;
    end while (baud_tick_o !== 1'h1 && t < 5000);
    hang(t == 5000);
  endtask : wt
  task tick(input logic [1:0] md);
    d = 16'($random(seed)) & 16'h011f;
    {wide_divisor_select_i, high_speed_select_i} = md;
    divisor_wdata_i = d;
    divisor_wr_i = 1;
    cyc(1);
    divisor_wr_i = 0;
    repeat (2) wt();
    cmp("tick gap", 16'(t), 16'(base(md) * ((md[1] ? d : d[7:0]) + 1)), 0);
  endtask : tick
  initial begin
    cyc(12);
    rst_n_i = 1;
    // Last case overflows the low byte on purpose
    for (int i = 0; i < 4; i++) calib(2'(i), i == 3 ? 300 : 20 + $random(seed) % 16, i == 2);
    for (int i = 0; i < 4; i++) tick(2'(i));
    results();
  end
endmodule : test_uabd_core
`default_nettype wire
